// ### logic/wdt_ctrl_pkg.sv
// Package with the constants and carrier types of the windowed watchdog control block.
package wdt_ctrl_pkg;

   // ***************************************************************
   // Register map and codes
   // ***************************************************************
   localparam int ADDR_W = 12;
   localparam logic [11:0] CTRL_ADDR = 12'hFD4;
   localparam logic [11:0] CODE_ADDR = 12'hFD5;
   localparam logic [11:0] COUNT_ADDR = 12'hFD6;
   localparam logic [11:0] STATUS_ADDR = 12'hFD7;
   localparam logic [7:0] CLEAR_CODE = 8'h4E;
   localparam logic [7:0] DISABLE_CODE = 8'hB1;
   localparam logic [1:0] CTRL_FIXED = 2'h2;
   localparam logic [4:0] STATUS_FIXED = 5'h0B;

   // ***************************************************************
   // Field encodings
   // ***************************************************************
   localparam logic [1:0] WIN_FULL = 2'h0;
   localparam logic [1:0] WIN_HALF = 2'h2;
   localparam logic [1:0] WIN_3Q = 2'h3;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [4:0] GEAR_SHIFT_BASE = 5'h0A;
   localparam logic [4:0] LF_SHIFT_BASE = 5'h03;
   localparam int PRE_W = 16;

   typedef struct packed {
      logic enable;
      logic [1:0] clear_window_select;
      logic [1:0] overflow_period_select;
      logic overflow_action_select;
   } ctrl_t;

   localparam ctrl_t CTRL_RESET = '{enable: 1'b1, clear_window_select: 2'h0,
                                    overflow_period_select: 2'h3, overflow_action_select: 1'b1};

endpackage : wdt_ctrl_pkg

// ### logic/wdt_prescaler.sv
// Source-clock prescaler that turns source ticks into 8-bit counter steps.
`timescale 1ns/10ps
module wdt_prescaler #(
   parameter int PRE_W = wdt_ctrl_pkg::PRE_W
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Control
   input wire logic tick_in,
   input wire logic clear_in,
   input wire logic [4:0] shift_in,
   // Result
   output logic step_out
);

   logic [PRE_W-1:0] pre;

   function automatic logic [PRE_W-1:0] low_mask(input logic [4:0] sh);
      low_mask = PRE_W'((32'h1 << sh) - 32'h1);
   endfunction : low_mask

   assign step_out = tick_in && ((pre & low_mask(shift_in)) == low_mask(shift_in));

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pre <= '0;
      end else if (clear_in) begin
         pre <= '0;
      end else if (tick_in) begin
         pre <= pre + PRE_W'(1);
      end
   end

endmodule : wdt_prescaler

// ### logic/windowed_watchdog_control.sv
// Control registers, clear window and overflow signalling of the 8-bit windowed watchdog.
// Functional notes
// (RULE_01) Period codes 10,11: 2^22/2^24 gear, else 2^15/2^17.
// (RULE_02) Action bit 0: overflow raises interrupt request.
// (RULE_03) Window 10: early clear interrupts; clears after half.
// (RULE_04) Window 11: early clear interrupts; clears after three-quarters.
// (RULE_05) Enable set locks window, period, action fields.
// (RULE_06) Software stops: clear enable, then write 0xB1.
// (RULE_07) Write setting enable also accepts new fields; the code takes them only once the 0xB1 disable code has stopped the count.
// (RULE_08) Control reads give bit7 one, bit6 zero.
// (RULE_09) Gear clock in normal mode, prescaler clear.
// (RULE_10) Period codes 00,01: 2^18/2^20 gear, else 2^11/2^13.
// (RULE_11) Code 0x4E clears counter; other codes ignored.
// (RULE_12) Window 00: clear allowed anytime, no interrupt.
// (RULE_13) Action bit 1: overflow raises reset request.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module windowed_watchdog_control (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [11:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   output logic [7:0] rd_data_out,
   // Count sources and operating mode
   input wire logic gear_tick_in,
   input wire logic low_freq_clock_tick_in,
   input wire logic normal_mode_in,
   input wire logic prescaler_select_bit_in,
   // Detection requests
   output logic wd_interrupt_out,
   output logic wd_reset_out
);

   // ***************************************************************
   // Decode
   // ***************************************************************
   wdt_ctrl_pkg::ctrl_t ctrl;
   wdt_ctrl_pkg::ctrl_t wr_ctrl_val;
   logic running;
   logic [7:0] count;
   logic early_flag;
   logic ovf_flag;
   logic wr_ctrl, wr_code, clear_code, disable_go, rd_status;
   logic use_gear, src_tick, step, good_clear, bad_clear, overflow;
   logic [4:0] shift;

   function automatic logic in_window(input logic [1:0] win, input logic [7:0] cnt);
      unique case (win)
         wdt_ctrl_pkg::WIN_HALF: in_window = cnt[7]; // [RULE_03]
         wdt_ctrl_pkg::WIN_3Q: in_window = &cnt[7:6]; // [RULE_04]
         default: in_window = 1'b1; // [RULE_12]
      endcase
   endfunction : in_window

   assign wr_ctrl_val = wdt_ctrl_pkg::ctrl_t'(wr_data_in[$bits(wdt_ctrl_pkg::ctrl_t)-1:0]);
   assign wr_ctrl = wr_en_in && (addr_in == wdt_ctrl_pkg::CTRL_ADDR);
   assign wr_code = wr_en_in && (addr_in == wdt_ctrl_pkg::CODE_ADDR);
   assign rd_status = rd_en_in && (addr_in == wdt_ctrl_pkg::STATUS_ADDR);
   // Any other code value falls through both compares and does nothing.
   assign clear_code = wr_code && (wr_data_in == wdt_ctrl_pkg::CLEAR_CODE); // [RULE_11]
   assign disable_go = wr_code && (wr_data_in == wdt_ctrl_pkg::DISABLE_CODE) && !ctrl.enable; // [RULE_06]
   assign good_clear = clear_code && running && in_window(ctrl.clear_window_select, count);
   assign bad_clear = clear_code && running && !in_window(ctrl.clear_window_select, count); // [RULE_03] [RULE_04]

   // ***************************************************************
   // Count source
   // ***************************************************************
   assign use_gear = normal_mode_in && !prescaler_select_bit_in; // [RULE_09]
   assign src_tick = running && (use_gear ? gear_tick_in : low_freq_clock_tick_in); // [RULE_09]
   // The 8-bit counter steps every 2^shift source ticks, so overflow is 2^(shift+8) ticks.
   assign shift = (use_gear ? wdt_ctrl_pkg::GEAR_SHIFT_BASE : wdt_ctrl_pkg::LF_SHIFT_BASE)
                  + {2'h0, ctrl.overflow_period_select, 1'b0}; // [RULE_01] [RULE_10]

   wdt_prescaler #(
      .PRE_W(wdt_ctrl_pkg::PRE_W)
   ) wdt_prescaler_inst (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .tick_in(src_tick),
      .clear_in(!running || good_clear || disable_go),
      .shift_in(shift),
      .step_out(step)
   );

   // A disable that meets an overflow wins and the overflow is dropped.
   // A clear taken in that same cycle wins too, so a timely clear never raises a request.
   assign overflow = step && (count == wdt_ctrl_pkg::COUNT_MAX) && !disable_go && !good_clear;

   // ***************************************************************
   // Control register and run state
   // ***************************************************************
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl <= wdt_ctrl_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl.enable <= wr_ctrl_val.enable;
         // Clearing enable alone does not unlock; only the disable code stops the count.
         if (!running) begin // [RULE_05] [RULE_07]
            ctrl.clear_window_select <= wr_ctrl_val.clear_window_select;
            ctrl.overflow_period_select <= wr_ctrl_val.overflow_period_select;
            ctrl.overflow_action_select <= wr_ctrl_val.overflow_action_select;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         running <= 1'b1;
      end else if (disable_go) begin
         running <= 1'b0; // [RULE_06]
      end else if (wr_ctrl && wr_ctrl_val.enable) begin
         running <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count <= '0;
      end else if (disable_go || good_clear) begin
         count <= '0; // [RULE_11] [RULE_12]
      end else if (step) begin
         count <= count + 8'h01;
      end
   end

   // ***************************************************************
   // Detection outputs and sticky status
   // ***************************************************************
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wd_interrupt_out <= 1'b0;
         wd_reset_out <= 1'b0;
      end else begin
         wd_interrupt_out <= bad_clear || (overflow && !ctrl.overflow_action_select); // [RULE_02] [RULE_03]
         wd_reset_out <= overflow && ctrl.overflow_action_select; // [RULE_13]
      end
   end

   // Setting wins over the clear-on-read so an event in the read cycle survives.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         early_flag <= 1'b0;
         ovf_flag <= 1'b0;
      end else begin
         early_flag <= bad_clear || (early_flag && !rd_status);
         ovf_flag <= (overflow && !ctrl.overflow_action_select) || (ovf_flag && !rd_status);
      end
   end

   // ***************************************************************
   // Read port
   // ***************************************************************
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_out <= '0;
      end else if (!rd_en_in) begin
         rd_data_out <= '0;
      end else begin
         unique case (addr_in)
            wdt_ctrl_pkg::CTRL_ADDR: rd_data_out <= {wdt_ctrl_pkg::CTRL_FIXED, ctrl}; // [RULE_08]
            wdt_ctrl_pkg::COUNT_ADDR: rd_data_out <= count;
            wdt_ctrl_pkg::STATUS_ADDR: rd_data_out <= {wdt_ctrl_pkg::STATUS_FIXED, ovf_flag, early_flag, running};
            default: rd_data_out <= '0;
         endcase
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   AST_OVF_RESET: assert property (overflow && ctrl.overflow_action_select |=> wd_reset_out && !wd_interrupt_out) // [RULE_13]
      else $error("overflow with reset action gave no reset request");
   AST_OVF_IRQ: assert property (overflow && !ctrl.overflow_action_select |=> wd_interrupt_out && !wd_reset_out && ovf_flag) // [RULE_02]
      else $error("overflow with interrupt action gave no interrupt");
   AST_EARLY_HALF: assert property (clear_code && running && ctrl.clear_window_select == wdt_ctrl_pkg::WIN_HALF && !count[7]
      |=> wd_interrupt_out && early_flag) // [RULE_03]
      else $error("early clear in half window not flagged");
   AST_EARLY_3Q: assert property (clear_code && running && ctrl.clear_window_select == wdt_ctrl_pkg::WIN_3Q
      && !(&count[7:6]) && !step |=> wd_interrupt_out && count == $past(count)) // [RULE_04]
      else $error("early clear in three-quarter window misbehaved");
   AST_LOCKED: assert property (wr_ctrl && running |=> ctrl.clear_window_select == $past(ctrl.clear_window_select)
      && ctrl.overflow_period_select == $past(ctrl.overflow_period_select)
      && ctrl.overflow_action_select == $past(ctrl.overflow_action_select)) // [RULE_05]
      else $error("locked field changed while running");
   AST_ACCEPT: assert property (wr_ctrl && !running |=> ctrl == $past(wr_ctrl_val) && running == $past(wr_ctrl_val.enable)) // [RULE_07]
      else $error("unlocked control write not taken");
   AST_FIXED_BITS: assert property (rd_en_in && addr_in == wdt_ctrl_pkg::CTRL_ADDR |=> rd_data_out[7:6] == 2'h2) // [RULE_08]
      else $error("control read fixed bits wrong");
   AST_FULL_WINDOW: assert property (clear_code && running && ctrl.clear_window_select == wdt_ctrl_pkg::WIN_FULL
      |=> count == 8'h00 && !wd_interrupt_out) // [RULE_12]
      else $error("clear in full window failed");
   AST_DISABLE: assert property (disable_go |=> !running && count == 8'h00 ##1 !wd_reset_out) // [RULE_06]
      else $error("disable code did not stop the counter");
   AST_SOURCE: assert property (step |-> (use_gear ? gear_tick_in : low_freq_clock_tick_in) && running) // [RULE_09]
      else $error("counter stepped without selected source tick");
   AST_BAD_CODE: assert property (wr_code && wr_data_in != wdt_ctrl_pkg::CLEAR_CODE
      && wr_data_in != wdt_ctrl_pkg::DISABLE_CODE && !step |=> count == $past(count) && running == $past(running)) // [RULE_11]
      else $error("invalid code had an effect");
   // These watch the internal decode, so a broken compare shows up before any read-back does.
   AST_STOPPED: assert property (!running |-> count == 8'h00 && !step) // [RULE_06]
      else $error("stopped watchdog counted");
   AST_START: assert property (wr_ctrl && wr_ctrl_val.enable |=> running && ctrl.enable) // [RULE_07]
      else $error("enable write did not start the watchdog");
   AST_WRAP: assert property (overflow && !ctrl.overflow_action_select |=> count == 8'h00) // [RULE_02]
      else $error("counter did not wrap after interrupt overflow");
   AST_FLAG_CLEAR: assert property (rd_status && !bad_clear |=> !early_flag) // [RULE_03]
      else $error("early clear flag survived a status read");
   AST_NO_IRQ_GOOD: assert property (good_clear && !overflow |=> !wd_interrupt_out && !wd_reset_out) // [RULE_12]
      else $error("accepted clear raised a request");

   COV_OVF: cover property (overflow ##1 wd_reset_out);
   COV_EARLY: cover property (bad_clear ##1 wd_interrupt_out);
   COV_DISABLE_REENABLE: cover property (disable_go ##[1:20] (wr_ctrl && wr_ctrl_val.enable));
   COV_OVF_IRQ: cover property ((overflow && !ctrl.overflow_action_select) ##1 wd_interrupt_out);

endmodule : windowed_watchdog_control

// ### dv/windowed_watchdog_control_tb.sv
// Self-checking testbench of the windowed watchdog control block.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin $display("wrong value %s expected %h seen %h", n, e, g); error_cnt++; end end
module windowed_watchdog_control_tb;
   // ***************************************************************
   // Stimulus and observation
   // ***************************************************************
   typedef struct {logic [1:0] per; logic nm; logic ps; logic g; logic l; int sh; logic [7:0] exp;} row_t;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [11:0] addr_in = 12'h000;
   logic [7:0] wr_data_in = 8'h00;
   logic wr_en_in = 1'b0;
   logic rd_en_in = 1'b0;
   logic gear_tick_in = 1'b0;
   logic lf_tick = 1'b0;
   logic normal_mode_in = 1'b0;
   logic presc = 1'b0;
   logic [7:0] rd_data_out;
   logic wd_interrupt_out;
   logic wd_reset_out;
   logic [7:0] d;
   int error_cnt = 0;
   int checks_done = 0;
   int irq_cnt = 0;
   int rst_cnt = 0;
   int n;
   int m;
   row_t rows [7];
   windowed_watchdog_control windowed_watchdog_control_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
      .rd_data_out(rd_data_out), .gear_tick_in(gear_tick_in), .low_freq_clock_tick_in(lf_tick),
      .normal_mode_in(normal_mode_in), .prescaler_select_bit_in(presc),
      .wd_interrupt_out(wd_interrupt_out), .wd_reset_out(wd_reset_out));
   initial begin
      forever #2 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      if (wd_interrupt_out === 1'b1) irq_cnt++;
      if (wd_reset_out === 1'b1) rst_cnt++;
   end
   // ***************************************************************
   // Bus and tick tasks
   // ***************************************************************
   task wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk_in);
      wr_en_in <= 1'b1;
      addr_in <= a;
      wr_data_in <= v;
      @(posedge clk_in);
      wr_en_in <= 1'b0;
   endtask : wr
   task rd(input logic [11:0] a);
      @(posedge clk_in);
      rd_en_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_en_in <= 1'b0;
      #1 d = rd_data_out;
   endtask : rd
   task ticks(input int k, input logic g, input logic l);
      repeat (k) begin
         @(posedge clk_in);
         gear_tick_in <= g;
         lf_tick <= l;
      end
      @(posedge clk_in);
      gear_tick_in <= 1'b0;
      lf_tick <= 1'b0;
   endtask : ticks
   task stop();
      wr(wdt_ctrl_pkg::CTRL_ADDR, 8'h00);
      wr(wdt_ctrl_pkg::CODE_ADDR, wdt_ctrl_pkg::DISABLE_CODE);
   endtask : stop
   task results();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results
   // Generous span: the whole sequence needs some 22000 cycles.
   initial begin
      #200000;
      error_cnt++;
      results();
   end
   // ***************************************************************
   // Tests
   // ***************************************************************
   initial begin
      rows[0] = '{2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 3, 8'h02};
      rows[1] = '{2'h1, 1'b0, 1'b0, 1'b0, 1'b1, 5, 8'h02};
      rows[2] = '{2'h2, 1'b0, 1'b0, 1'b0, 1'b1, 7, 8'h02};
      rows[3] = '{2'h3, 1'b1, 1'b1, 1'b0, 1'b1, 9, 8'h02};
      rows[4] = '{2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 10, 8'h02};
      rows[5] = '{2'h0, 1'b1, 1'b0, 1'b0, 1'b1, 4, 8'h00};
      rows[6] = '{2'h1, 1'b1, 1'b0, 1'b1, 1'b0, 12, 8'h02};
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(wdt_ctrl_pkg::CTRL_ADDR);
      `CHK("ctrl reset", 8'hA7, d)
      wr(wdt_ctrl_pkg::CODE_ADDR, wdt_ctrl_pkg::DISABLE_CODE);
      wr(wdt_ctrl_pkg::CTRL_ADDR, 8'h00);
      rd(wdt_ctrl_pkg::CTRL_ADDR);
      `CHK("ctrl locked", 8'h87, d)
      wr(wdt_ctrl_pkg::CODE_ADDR, wdt_ctrl_pkg::DISABLE_CODE);
      wr(wdt_ctrl_pkg::CTRL_ADDR, 8'h0A);
      rd(wdt_ctrl_pkg::CTRL_ADDR);
      `CHK("ctrl unlocked", 8'h8A, d)
      wr(wdt_ctrl_pkg::CTRL_ADDR, 8'h3D);
      rd(wdt_ctrl_pkg::CTRL_ADDR);
      `CHK("ctrl enable write", 8'hBD, d)
      wr(wdt_ctrl_pkg::CTRL_ADDR, 8'hC0);
      rd(wdt_ctrl_pkg::CTRL_ADDR);
      `CHK("ctrl relock", 8'h9D, d)
      $display("test lock done");
      // Tick counts sit mid-step so the prescaler phase cannot move the result.
      foreach (rows[i]) begin
         stop();
         normal_mode_in <= rows[i].nm;
         presc <= rows[i].ps;
         wr(wdt_ctrl_pkg::CTRL_ADDR, {3'h1, 2'h0, rows[i].per, 1'b0});
         ticks((2 << rows[i].sh) + (1 << (rows[i].sh - 1)), rows[i].g, rows[i].l);
         rd(wdt_ctrl_pkg::COUNT_ADDR);
         `CHK("count", rows[i].exp, d)
      end
      $display("test periods done");
      normal_mode_in <= 1'b0;
      for (int w = 2; w < 4; w++) begin
         stop();
         wr(wdt_ctrl_pkg::CTRL_ADDR, {3'h1, w[1:0], 3'h0});
         n = irq_cnt;
         ticks(w == 2 ? 1004 : 1508, 1'b0, 1'b1);
         wr(wdt_ctrl_pkg::CODE_ADDR, wdt_ctrl_pkg::CLEAR_CODE);
         rd(wdt_ctrl_pkg::STATUS_ADDR);
         `CHK("early irq", n + 1, irq_cnt)
         `CHK("early flag", 1'b1, d[1])
         rd(wdt_ctrl_pkg::COUNT_ADDR);
         `CHK("early count", (w == 2 ? 8'h7D : 8'hBC), d)
         ticks(40, 1'b0, 1'b1);
         wr(wdt_ctrl_pkg::CODE_ADDR, wdt_ctrl_pkg::CLEAR_CODE);
         rd(wdt_ctrl_pkg::COUNT_ADDR);
         `CHK("late count", 8'h00, d)
         `CHK("late irq", n + 1, irq_cnt)
      end
      $display("test window done");
      stop();
      wr(wdt_ctrl_pkg::CTRL_ADDR, 8'h20);
      n = irq_cnt;
      ticks(100, 1'b0, 1'b1);
      wr(wdt_ctrl_pkg::CODE_ADDR, 8'h55);
      rd(wdt_ctrl_pkg::COUNT_ADDR);
      `CHK("other code", 8'h0C, d)
      wr(wdt_ctrl_pkg::CODE_ADDR, wdt_ctrl_pkg::CLEAR_CODE);
      rd(wdt_ctrl_pkg::COUNT_ADDR);
      `CHK("full window clear", 8'h00, d)
      `CHK("full window irq", n, irq_cnt)
      $display("test codes done");
      for (int a = 0; a < 2; a++) begin
         stop();
         wr(wdt_ctrl_pkg::CTRL_ADDR, {7'h10, a[0]});
         n = irq_cnt;
         m = rst_cnt;
         ticks(2044, 1'b0, 1'b1);
         `CHK("no early overflow", n + m, irq_cnt + rst_cnt)
         ticks(8, 1'b0, 1'b1);
         `CHK("overflow irq", n + (a == 0 ? 1 : 0), irq_cnt)
         `CHK("overflow rst", m + a, rst_cnt)
         rd(wdt_ctrl_pkg::STATUS_ADDR);
         `CHK("overflow status", (a == 0 ? 8'h5D : 8'h59), d)
      end
      $display("test overflow done");
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(wdt_ctrl_pkg::CTRL_ADDR);
      `CHK("ctrl second reset", 8'hA7, d)
      @(posedge clk_in);
      #1 `CHK("read data idle", 8'h00, rd_data_out)
      $display("test reset done");
      results();
   end
endmodule : windowed_watchdog_control_tb
